/* File: smi_dev_end.sv */
// Management slave end: frame decoder on the link clock, user side on clk
//
// Contract
// - Thirty-two one bits preamble once after reset
// - Frame starts with pattern 01
// - Opcode 10 reads, 01 writes
// - Ten-bit address, MSB first
// - Read turnaround two bits, slave takes over
// - Sixteen data bits, read driven, write stored
// - Later frames need no preamble, one idle
// - Address mismatch keeps data pin released
// - Shift logic works up to 25 MHz
// - Line released outside read data, reads one
// - Select pin held low during management
// - Shared pins stay inputs for management
// - Decode basic, extended, counter and PHY maps
// - Extended map end is a parameter
// - Master splits address into 5+5 fields
// - PHY field 10000 reaches port PHYs
// - Strap low at reset selects 16-bit mode
// - Active-low interrupt output for switch events
// - Master releases pins during EEPROM load; data and select are released, the clock pin stays driven low
`timescale 1ns/100ps
module smi_dev_end
  import smi_pkg::*;
#(
  parameter logic [9:0] EXT_END = MAP_EXT_END
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  smi_if.dev               m,
  input  wire logic        smi_width_strap,
  input  wire logic [3:0]  irq_events,
  output logic             wr_valid,
  output logic [9:0]       wr_addr,
  output logic [15:0]      wr_data
);
  localparam int WORDS = 2 ** ADDR_W;

  typedef struct packed {
    smi_lk_st_type st;
    logic [4:0]    cnt;
    logic [1:0]    op;
    logic [9:0]    addr;
    logic [15:0]   sh;
    logic          hit;
    logic          is_rd;
    logic          dout;
    logic          doe;
    logic          wr_en;
    logic          wtog;
    logic [9:0]    waddr;
    logic [15:0]   wdata;
    logic [1:0]    strap_cnt;
    logic          strap_done;
    logic          mode16;
  } smi_lk_type;

  typedef struct packed {
    logic        tog_d;
    logic        wr_valid;
    logic [9:0]  wr_addr;
    logic [15:0] wr_data;
    logic        int_n;
  } smi_us_type;

  smi_lk_type lk_r;
  smi_lk_type lk_nxt;
  smi_us_type us_r;
  smi_us_type us_nxt;

  logic [15:0]      mem [WORDS];
  logic [WORDS-1:0] vld_r;
  logic [1:0]       pin_s;
  logic             tog_s;
  logic             bit_in;
  logic [15:0]      rd_word;
  logic [9:0]       full_addr;

  function automatic logic in_map(input logic [9:0] a,
                                  input logic [9:0] ext_end);
    in_map = (a <= MAP_BASIC_END) ||
             (a >= MAP_EXT_BASE && a <= ext_end) ||
             (a >= MAP_CNT_BASE && a <= MAP_CNT_END) ||
             (a >= MAP_PHY_BASE && a <= MAP_PHY_END);
  endfunction : in_map

  // Select and strap come from outside the link domain
  smi_sync #(
    .W (2)
  ) u_pin_sync (
    .clk  (m.mgmt_clock_pin),
    .rstn (rstn),
    .d    ({m.eeprom_select_pin, smi_width_strap}),
    .q    (pin_s)
  );

  smi_sync #(
    .W (1)
  ) u_tog_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (lk_r.wtog),
    .q    (tog_s)
  );

  // Data pin belongs to the link domain; sampled on the rising edge
  assign bit_in = m.mgmt_data_pin;
  assign rd_word = vld_r[lk_r.addr] ? mem[lk_r.addr] : 16'h0;
  assign full_addr = {lk_r.addr[8:0], bit_in};

  always_comb begin
    lk_nxt = lk_r;
    lk_nxt.wr_en = 1'b0;
    if (!lk_r.strap_done) begin
      lk_nxt.strap_cnt = lk_r.strap_cnt + 2'h1;
      if (lk_r.strap_cnt == STRAP_WAIT) begin
        lk_nxt.strap_done = 1'b1;
        lk_nxt.mode16 = ~pin_s[0];
      end
    end
    case (lk_r.st)
      LK_INIT: begin
        if (bit_in) begin
          lk_nxt.cnt = lk_r.cnt + 5'h1;
          if (lk_r.cnt == PRE_LAST) begin
            lk_nxt.st = LK_IDLE;
          end
        end else begin
          lk_nxt.cnt = 5'h0;
        end
      end
      LK_IDLE: begin
        if (!bit_in) begin
          lk_nxt.st = LK_SOF;
        end
      end
      LK_SOF: begin
        lk_nxt.cnt = 5'h0;
        lk_nxt.st = bit_in ? LK_OP : LK_GAP;
      end
      LK_OP: begin
        lk_nxt.op = {lk_r.op[0], bit_in};
        lk_nxt.cnt = lk_r.cnt + 5'h1;
        if (lk_r.cnt == OP_LAST) begin
          lk_nxt.cnt = 5'h0;
          lk_nxt.st = LK_ADDR;
        end
      end
      LK_ADDR: begin
        lk_nxt.addr = full_addr;
        lk_nxt.cnt = lk_r.cnt + 5'h1;
        if (lk_r.cnt == ADDR_LAST) begin
          lk_nxt.cnt = 5'h0;
          lk_nxt.st = LK_TA;
          lk_nxt.is_rd = (lk_r.op == OP_RD);
          lk_nxt.hit = in_map(full_addr, EXT_END) &&
                       lk_r.strap_done && lk_r.mode16 &&
                       !pin_s[1] &&
                       (lk_r.op == OP_RD || lk_r.op == OP_WR);
        end
      end
      LK_TA: begin
        // Write turnaround values are not looked at
        lk_nxt.cnt = lk_r.cnt + 5'h1;
        if (lk_r.cnt != TA_LAST) begin
          if (lk_r.hit && lk_r.is_rd) begin
            lk_nxt.doe = 1'b1;
            lk_nxt.dout = 1'b0;
          end
        end else begin
          lk_nxt.cnt = 5'h0;
          lk_nxt.st = LK_DATA;
          if (lk_r.hit && lk_r.is_rd) begin
            lk_nxt.dout = rd_word[15];
            lk_nxt.sh = {rd_word[14:0], 1'b0};
          end
        end
      end
      LK_DATA: begin
        lk_nxt.cnt = lk_r.cnt + 5'h1;
        if (lk_r.is_rd) begin
          lk_nxt.dout = lk_r.sh[15];
          lk_nxt.sh = {lk_r.sh[14:0], 1'b0};
        end else begin
          lk_nxt.sh = {lk_r.sh[14:0], bit_in};
        end
        if (lk_r.cnt == DATA_LAST) begin
          lk_nxt.st = LK_GAP;
          lk_nxt.doe = 1'b0;
          lk_nxt.dout = 1'b1;
          if (lk_r.hit && !lk_r.is_rd) begin
            lk_nxt.wr_en = 1'b1;
            lk_nxt.wtog = ~lk_r.wtog;
            lk_nxt.waddr = lk_r.addr;
            lk_nxt.wdata = {lk_r.sh[14:0], bit_in};
          end
        end
      end
      LK_GAP: begin
        if (bit_in) begin
          lk_nxt.st = LK_IDLE;
        end
      end
      default: begin
        lk_nxt.st = LK_INIT;
        lk_nxt.doe = 1'b0;
      end
    endcase
  end

  // Plain edge-triggered shift path, no extra clock cycles needed
  always_ff @(posedge m.mgmt_clock_pin or negedge rstn) begin
    if (!rstn) begin
      lk_r <= '{st: LK_INIT, dout: 1'b1, default: '0};
    end else begin
      lk_r <= lk_nxt;
    end
  end

  always_ff @(posedge m.mgmt_clock_pin) begin
    if (lk_r.wr_en) begin
      mem[lk_r.waddr] <= lk_r.wdata;
    end
  end

  always_ff @(posedge m.mgmt_clock_pin or negedge rstn) begin
    if (!rstn) begin
      vld_r <= '0;
    end else if (lk_r.wr_en) begin
      vld_r[lk_r.waddr] <= 1'b1;
    end
  end

  // Address and data are held until the next write, far beyond the sync
  always_comb begin
    us_nxt = us_r;
    us_nxt.tog_d = tog_s;
    us_nxt.wr_valid = tog_s ^ us_r.tog_d;
    if (tog_s ^ us_r.tog_d) begin
      us_nxt.wr_addr = lk_r.waddr;
      us_nxt.wr_data = lk_r.wdata;
    end
    us_nxt.int_n = ~|irq_events;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      us_r <= '{int_n: 1'b1, default: '0};
    end else begin
      us_r <= us_nxt;
    end
  end

  // Slave never drives select or the EEPROM pins
  assign m.dev_data_o = lk_r.dout;
  assign m.dev_data_oe = lk_r.doe;
  assign m.int_n = us_r.int_n;
  assign wr_valid = us_r.wr_valid;
  assign wr_addr = us_r.wr_addr;
  assign wr_data = us_r.wr_data;
endmodule : smi_dev_end

/* File: smi_pkg.sv */
// Shared constants and types for the serial management slave and master
package smi_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int PRE_BITS = 32;
  localparam logic [1:0] SOF_PAT = 2'h1;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [1:0] TA_WR = 2'h2;
  localparam logic [4:0] PRE_LAST = 5'h1f;
  localparam logic [4:0] OP_LAST = 5'h01;
  localparam logic [4:0] ADDR_LAST = 5'h09;
  localparam logic [4:0] TA_LAST = 5'h01;
  localparam logic [4:0] DATA_LAST = 5'h0f;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [9:0] MAP_BASIC_END = 10'h03f;
  localparam logic [9:0] MAP_EXT_BASE = 10'h040;
  localparam logic [9:0] MAP_EXT_END = 10'h09c;
  localparam logic [9:0] MAP_CNT_BASE = 10'h0a0;
  localparam logic [9:0] MAP_CNT_END = 10'h143;
  localparam logic [9:0] MAP_PHY_BASE = 10'h200;
  localparam logic [9:0] MAP_PHY_END = 10'h2ff;
  localparam logic [4:0] PHY_SEL = 5'h10;
  localparam logic [5:0] FRAME_LAST = 6'h1f;
  localparam logic [5:0] RD_REL_CNT = 6'h11;
  localparam logic [5:0] DATA_TOP = 6'h0f;
  localparam logic [5:0] PRE_CNT = 6'h20;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MDC_MAX_MHZ = 25;
  localparam int MDC_HALF_NS = 100;
  localparam int MDC_HALF_CYC =
    (MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] MDC_HALF_LAST = 2'(MDC_HALF_CYC - 1);
  localparam int EE_LOAD_MS = 30;
  localparam int EE_LOAD_CYC = EE_LOAD_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    LK_INIT = 3'h0,
    LK_IDLE = 3'h1,
    LK_SOF  = 3'h3,
    LK_OP   = 3'h2,
    LK_ADDR = 3'h6,
    LK_TA   = 3'h7,
    LK_DATA = 3'h5,
    LK_GAP  = 3'h4
  } smi_lk_st_type;

  typedef enum logic [1:0] {
    HS_LOAD = 2'h0,
    HS_PRE  = 2'h1,
    HS_IDLE = 2'h3,
    HS_SEND = 2'h2
  } smi_hs_st_type;

  // Register address from a 5-bit device field and a 5-bit register field
  function automatic logic [9:0] smi_mdio_addr(input logic [4:0] phy,
                                               input logic [4:0] rg);
    smi_mdio_addr = {phy, rg};
  endfunction : smi_mdio_addr
endpackage : smi_pkg

/* File: smi_if.sv */
// Two-wire management link between master and slave
`timescale 1ns/100ps
interface smi_if;
  logic mgmt_clock_pin;
  logic host_data_o;
  logic host_data_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic mgmt_data_pin;
  logic sel_o;
  logic sel_oe;
  logic eeprom_select_pin;
  logic int_n;

  // Pull-up on the data wire, pull-down on the select wire
  assign mgmt_data_pin = ~((host_data_oe & ~host_data_o) |
                           (dev_data_oe & ~dev_data_o));
  assign eeprom_select_pin = sel_oe & sel_o;

  modport host (
    output mgmt_clock_pin,
    output host_data_o,
    output host_data_oe,
    output sel_o,
    output sel_oe,
    input  mgmt_data_pin,
    input  int_n
  );
  modport dev (
    input  mgmt_clock_pin,
    input  mgmt_data_pin,
    input  eeprom_select_pin,
    output dev_data_o,
    output dev_data_oe,
    output int_n
  );
endinterface : smi_if

/* File: smi_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/100ps
module smi_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } smi_sync_type;

  smi_sync_type r;
  smi_sync_type n;

  always_comb begin
    n = r;
    n.s1 = d;
    n.s2 = r.s1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q = r.s2;
endmodule : smi_sync

/* File: smi_host_end.sv */
// Management master end: divides clk into the link clock and runs frames
`timescale 1ns/100ps
module smi_host_end
  import smi_pkg::*;
#(
  parameter int LOAD_CYC = EE_LOAD_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  smi_if.host              m,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_write,
  input  wire logic [4:0]  cmd_phy,
  input  wire logic [4:0]  cmd_reg,
  input  wire logic [15:0] cmd_wdata,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  output logic             irq
);
  typedef struct packed {
    smi_hs_st_type st;
    logic [1:0]    div;
    logic          mdc;
    logic          dout;
    logic          doe;
    logic          sel_oe;
    logic [5:0]    cnt;
    logic [19:0]   load;
    logic          pend;
    logic          pwr;
    logic [9:0]    paddr;
    logic [15:0]   pdata;
    logic [31:0]   sh;
    logic          rd;
    logic [15:0]   rdata;
    logic          rsp_valid;
    logic [15:0]   rsp_rdata;
    logic          ready;
    logic          irq;
  } smi_hs_type;

  smi_hs_type r;
  smi_hs_type n;
  logic [1:0]  in_s;
  logic        tick;
  logic        rise;
  logic        fall;
  logic [31:0] frame;
  logic [5:0]  nc;

  smi_sync #(
    .W (2)
  ) u_in_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({m.int_n, m.mgmt_data_pin}),
    .q    (in_s)
  );

  assign tick = (r.div == MDC_HALF_LAST) && (r.st != HS_LOAD);
  assign rise = tick && !r.mdc;
  assign fall = tick && r.mdc;
  assign nc = r.cnt - 6'h1;
  assign frame = {SOF_PAT, r.pwr ? OP_WR : OP_RD, r.paddr,
                  r.pwr ? TA_WR : 2'h0,
                  r.pwr ? r.pdata : 16'h0};

  always_comb begin
    n = r;
    n.rsp_valid = 1'b0;
    n.irq = ~in_s[1];
    if (r.st != HS_LOAD) begin
      n.div = tick ? 2'h0 : r.div + 2'h1;
      n.mdc = tick ? ~r.mdc : r.mdc;
    end
    if (cmd_valid && r.ready) begin
      n.pend = 1'b1;
      n.pwr = cmd_write;
      n.paddr = smi_mdio_addr(cmd_phy, cmd_reg);
      n.pdata = cmd_wdata;
    end
    case (r.st)
      HS_LOAD: begin
        n.doe = 1'b0;
        n.sel_oe = 1'b0;
        n.load = r.load + 20'h1;
        if (r.load == 20'(LOAD_CYC - 1)) begin
          n.st = HS_PRE;
          n.sel_oe = 1'b1;
          n.cnt = PRE_CNT;
        end
      end
      HS_PRE: begin
        if (fall) begin
          if (r.cnt != 6'h0) begin
            n.doe = 1'b1;
            n.dout = 1'b1;
            n.cnt = nc;
          end else begin
            n.st = HS_IDLE;
            n.doe = 1'b0;
          end
        end
      end
      HS_IDLE: begin
        if (fall) begin
          n.doe = 1'b0;
          if (r.pend) begin
            n.st = HS_SEND;
            n.pend = 1'b0;
            n.rd = ~r.pwr;
            n.cnt = FRAME_LAST;
            n.doe = 1'b1;
            n.dout = frame[31];
            n.sh = {frame[30:0], 1'b0};
          end
        end
      end
      HS_SEND: begin
        if (rise && r.rd && r.cnt <= DATA_TOP) begin
          n.rdata = {r.rdata[14:0], in_s[0]};
        end
        if (fall) begin
          if (r.cnt == 6'h0) begin
            // This bit time is the idle bit before the next frame
            n.st = HS_IDLE;
            n.doe = 1'b0;
            n.rsp_valid = 1'b1;
            n.rsp_rdata = r.rd ? r.rdata : 16'h0;
          end else begin
            n.cnt = nc;
            n.dout = r.sh[31];
            n.sh = {r.sh[30:0], 1'b0};
            n.doe = ~r.rd || (nc > RD_REL_CNT);
          end
        end
      end
      default: begin
        n.st = HS_LOAD;
      end
    endcase
    n.ready = (n.st != HS_LOAD) && !n.pend;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{st: HS_LOAD, dout: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  assign m.mgmt_clock_pin = r.mdc;
  assign m.host_data_o = r.dout;
  assign m.host_data_oe = r.doe;
  assign m.sel_o = 1'b0;
  assign m.sel_oe = r.sel_oe;
  assign cmd_ready = r.ready;
  assign rsp_valid = r.rsp_valid;
  assign rsp_rdata = r.rsp_rdata;
  assign irq = r.irq;
endmodule : smi_host_end

/* File: smi_link_assertions.sv */
// Assertions on the management link between both ends
`timescale 1ns/100ps
module smi_link_assertions (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic mgmt_clock_pin,
  input  wire logic host_data_oe,
  input  wire logic dev_data_o,
  input  wire logic dev_data_oe,
  input  wire logic mgmt_data_pin,
  input  wire logic eeprom_select_pin,
  input  wire logic sel_oe
);
  logic [6:0] oe_cnt_r;
  logic [5:0] ones_r;
  logic       mdc_q_r;
  logic       pre_seen_r;
  logic       mdc_rise;

  assign mdc_rise = mgmt_clock_pin & ~mdc_q_r;

  // Counts read drive length and the opening run of ones
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oe_cnt_r   <= 7'h00;
      ones_r     <= 6'h00;
      mdc_q_r    <= 1'b0;
      pre_seen_r <= 1'b0;
    end else begin
      mdc_q_r    <= mgmt_clock_pin;
      oe_cnt_r   <= dev_data_oe ? oe_cnt_r + 7'h01 : 7'h00;
      pre_seen_r <= pre_seen_r | (ones_r >= 6'h20);
      if (mdc_rise) begin
        ones_r <= !mgmt_data_pin ? 6'h00 :
                  (ones_r >= 6'h20) ? ones_r : ones_r + 6'h01;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_no_contention: assert property (!(host_data_oe && dev_data_oe))
    else $error("both ends drive the data wire");
  a_idle_pullup: assert property (
    !host_data_oe && !dev_data_oe |-> mgmt_data_pin)
    else $error("released data wire not high");
  a_ta_handover: assert property (
    $rose(dev_data_oe) |-> !host_data_oe && $past(!host_data_oe))
    else $error("slave drove before master released");
  a_ta_zero: assert property ($rose(dev_data_oe) |-> !dev_data_o)
    else $error("slave turnaround bit not zero");
  a_preamble_first: assert property ($rose(dev_data_oe) |-> pre_seen_r)
    else $error("slave answered before full preamble");
  a_read_length: assert property (
    $fell(dev_data_oe) |-> oe_cnt_r >= 7'h42 && oe_cnt_r <= 7'h46)
    else $error("slave read drive length wrong");
  a_bit_on_rise: assert property (
    $changed(dev_data_o) && dev_data_oe && $past(dev_data_oe)
    |-> mgmt_clock_pin)
    else $error("slave read bit changed off link clock rise");
  a_select_low: assert property (
    host_data_oe |-> sel_oe && !eeprom_select_pin)
    else $error("select not driven low while master drives");
  a_release_gap: assert property (
    $fell(dev_data_oe) |-> !dev_data_oe [*4])
    else $error("slave drove again right after read");

  c_read: cover property ($rose(dev_data_oe));
  c_preamble: cover property ($rose(pre_seen_r));
  c_host_frame: cover property ($fell(host_data_oe));
endmodule : smi_link_assertions

/* File: test_smi_management_slave.sv */
// Self-checking bench joining both management link ends
`timescale 1ns/100ps
module test_smi_management_slave;
  import smi_pkg::*;
  logic        clk;
  logic        rstn;
  logic        strap;
  logic [3:0]  irq_events;
  logic        wr_valid;
  logic [9:0]  wr_addr;
  logic [15:0] wr_data;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_write;
  logic [9:0]  cmd_addr;
  logic [15:0] cmd_wdata;
  logic        rsp_valid;
  logic [15:0] rsp_rdata;
  logic        irq;
  logic [9:0]  a;
  int          n_fail;
  int          comparisons;
  int          seed;
  int          wr_cnt;
  logic [15:0] mem [0:1023];
  logic        known [0:1023];
  logic [9:0]  edges [12] = '{10'h000, 10'h03f, 10'h040, 10'h09c, 10'h09d,
    10'h0a0, 10'h143, 10'h144, 10'h1ff, 10'h200, 10'h2ff, 10'h3ff};

  smi_if m ();
  smi_dev_end i_smi_dev_end (.clk(clk), .rstn(rstn), .m(m.dev),
    .smi_width_strap(strap), .irq_events(irq_events),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data));
  smi_host_end #(.LOAD_CYC(8)) i_smi_host_end (.clk(clk), .rstn(rstn),
    .m(m.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_phy(cmd_addr[9:5]),
    .cmd_reg(cmd_addr[4:0]), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .irq(irq));
  smi_link_assertions i_smi_link_assertions (.clk(clk), .rstn(rstn),
    .mgmt_clock_pin(m.mgmt_clock_pin), .host_data_oe(m.host_data_oe),
    .dev_data_o(m.dev_data_o), .dev_data_oe(m.dev_data_oe),
    .mgmt_data_pin(m.mgmt_data_pin),
    .eeprom_select_pin(m.eeprom_select_pin), .sel_oe(m.sel_oe));

  always #25 clk = ~clk;

  always @(negedge clk) begin
    if (wr_valid === 1'b1) begin
      wr_cnt++;
    end
  end

  function automatic logic in_map(input logic [9:0] x);
    in_map = x <= MAP_BASIC_END ||
             (x >= MAP_EXT_BASE && x <= MAP_EXT_END) ||
             (x >= MAP_CNT_BASE && x <= MAP_CNT_END) ||
             (x >= MAP_PHY_BASE && x <= MAP_PHY_END);
  endfunction : in_map

  // Unmapped or strap-high reads see the pulled-up wire
  function automatic logic [15:0] exp_rd(input logic [9:0] x);
    exp_rd = strap || !in_map(x) ? 16'hffff : known[x] ? mem[x] : 16'h0000;
  endfunction : exp_rd

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t word got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : chk_flag

  task automatic run(input logic wr, input logic [9:0] x,
                     input logic [15:0] d);
    int n;
    int w0;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    irq_events = 4'($random(seed));
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = x;
    cmd_wdata = d;
    w0 = wr_cnt;
    @(negedge clk);
    cmd_valid = 1'b0;
    chk_flag(cmd_ready, 1'b0);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk_flag(rsp_valid, 1'b1);
    if (wr) begin
      chk_word(rsp_rdata, 16'h0000);
    end else begin
      chk_word(rsp_rdata, exp_rd(x));
    end
    repeat (8) @(negedge clk);
    chk_word(16'(wr_cnt - w0),
             {15'h0, wr & in_map(x) & !strap});
    if (wr && in_map(x) && !strap) begin
      chk_word({6'h00, wr_addr}, {6'h00, x});
      chk_word(wr_data, d);
      mem[x] = d;
      known[x] = 1'b1;
    end
    chk_flag(irq, |irq_events);
  endtask : run

  task automatic end_sim;
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim;
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    strap = 1'b0;
    irq_events = 4'h0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 10'h000;
    cmd_wdata = 16'h0000;
    n_fail = 0;
    comparisons = 0;
    seed = 87347;
    wr_cnt = 0;
    foreach (known[i]) known[i] = 1'b0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    run(1'b0, 10'h0a1, 16'h0000);
    foreach (edges[i]) run(1'b1, edges[i], 16'($random(seed)));
    foreach (edges[i]) run(1'b0, edges[i], 16'h0000);
    for (int i = 0; i < 6; i++) begin
      a = 10'($random(seed));
      run(1'b1, a, 16'($random(seed)));
      run(1'b0, a, 16'h0000);
    end
    // Reset again with the strap high: frames must be ignored
    rstn = 1'b0;
    strap = 1'b1;
    foreach (known[i]) known[i] = 1'b0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    run(1'b1, 10'h002, 16'h2600);
    run(1'b0, 10'h002, 16'h0000);
    // Reset with the strap low: new preamble, stored words cleared
    rstn = 1'b0;
    strap = 1'b0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    run(1'b0, a, 16'h0000);
    run(1'b1, 10'h2a5, 16'h5a3c);
    run(1'b0, 10'h2a5, 16'h0000);
    end_sim;
  end
endmodule : test_smi_management_slave
